// [hw/pcl_defs.svh]
`ifndef PCL_DEFS_SVH
`define PCL_DEFS_SVH

// Configuration-space byte offsets
`define PCL_OFS_CSR        8'h40
`define PCL_OFS_DATA       8'h44
// Control/status bit positions
`define PCL_BIT_IDLE_SCAN  0
`define PCL_BIT_DONE       1
`define PCL_BIT_INIT       2
`define PCL_BIT_VALID      3
`define PCL_BIT_EMPTY      4
`define PCL_BIT_FULL       5
`define PCL_BIT_PROGRAM_N  8
`define PCL_BIT_CONFIG     9
`define PCL_BIT_RDBACK_N   10
// Reset values
`define PCL_CTRL_RESET     3'h5
`define PCL_WORD_ZERO      32'h0000_0000
`define PCL_CSR_ZERO       16'h0000
// Shift register geometry
`define PCL_SHIFT_LAST     5'h1F
`define PCL_SHIFT_ZERO     5'h00
`define PCL_SHIFT_ONE      5'h01
// Readback pacing, one bit per four cycles
`define PCL_PACE_ZERO      2'h0
`define PCL_PACE_ONE       2'h1
`define PCL_PACE_LAST      2'h3
// Synchroniser reset image: program pin idles high
`define PCL_SRC_IDLE       3'h1
// Configuration RAM clearing time after the session starts
`define PCL_CLEAR_NS       1000
`define PCL_CLK_NS         50
`define PCL_CLEAR_CYCLES   ((`PCL_CLEAR_NS + `PCL_CLK_NS - 1) / `PCL_CLK_NS)
`define PCL_CLEAR_W        6
`define PCL_CLEAR_LAST     6'(`PCL_CLEAR_CYCLES - 1)
`define PCL_CLEAR_ZERO     6'h00
`define PCL_CLEAR_ONE      6'h01

`endif

// [hw/pcl_pkg.sv]
package pcl_pkg;
   typedef enum logic [1:0] {
      PCL_IDLE  = 2'b00,
      PCL_CLEAR = 2'b01,
      PCL_LOAD  = 2'b10,
      PCL_READ  = 2'b11
   } pcl_state_type;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } pcl_cfg_req_type;

   typedef struct packed {
      logic strap_busy;
      logic scan_busy;
      logic program_pin_n;
   } pcl_sources_type;
endpackage

// [hw/pcl_loader.sv]
`timescale 1ns/1ps
`include "pcl_defs.svh"

module pcl_loader
   import pcl_pkg::*;
(
   // Clock and reset
   input  wire logic            mclk,
   input  wire logic            rst,
   // Configuration-space access
   input  wire pcl_cfg_req_type cfg_req,
   output logic [31:0]          cfg_rdata,
   // Competing configuration sources, from pins
   input  wire pcl_sources_type sources,
   input  wire logic            preconfig_done,
   // Serial configuration stream
   output logic                 cfg_serial_data,
   output logic                 cfg_serial_valid,
   output logic                 cfg_abort_strap,
   input  wire logic            cfg_load_done,
   input  wire logic            rdback_bit,
   output logic                 rdback_shift
);

   pcl_sources_type src_meta;
   pcl_sources_type src_sync;
   logic [1:0]      done_meta;
   logic [1:0]      done_sync;
   logic            rdbit_meta;
   logic            rdbit_sync;

   pcl_state_type   state;
   logic [2:0]      ctrl;
   logic [31:0]     data_word;
   logic [31:0]     shift_word;
   logic [4:0]      shift_count;
   logic [5:0]      clear_count;
   logic            word_valid;
   logic            shift_empty;
   logic            shift_full;
   logic            init_ok;
   logic            done_flag;
   logic [1:0]      read_pace;

   pcl_state_type   next_state;

   // Pin inputs pass two flip-flops before any use
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         // Idle level, or a false pin abort follows every reset
         src_meta   <= pcl_sources_type'(`PCL_SRC_IDLE);
         src_sync   <= pcl_sources_type'(`PCL_SRC_IDLE);
         done_meta  <= 2'h0;
         done_sync  <= 2'h0;
         rdbit_meta <= 1'b0;
         rdbit_sync <= 1'b0;
      end else begin
         src_meta   <= sources;
         src_sync   <= src_meta;
         done_meta  <= {cfg_load_done, preconfig_done};
         done_sync  <= done_meta;
         rdbit_meta <= rdback_bit;
         rdbit_sync <= rdbit_meta;
      end
   end

   wire csr_hit     = cfg_req.addr == `PCL_OFS_CSR;
   wire data_hit    = cfg_req.addr == `PCL_OFS_DATA;
   wire csr_wr      = cfg_req.wr && csr_hit;
   wire data_wr     = cfg_req.wr && data_hit;
   wire data_rd     = cfg_req.rd && data_hit;
   wire config_bit  = ctrl[1];
   wire rdback_bit_n = ctrl[2];
   wire program_n   = ctrl[0];
   wire wr_config   = cfg_req.wdata[`PCL_BIT_CONFIG];
   wire scan_hold   = src_sync.scan_busy;
   wire pin_hold    = !src_sync.program_pin_n;
   wire kill        = pin_hold || scan_hold || !program_n;
   wire shift_last  = shift_count == `PCL_SHIFT_LAST;
   wire clear_last  = clear_count == `PCL_CLEAR_LAST;
   wire take_word   = state == PCL_LOAD && word_valid && shift_empty;
   wire shift_step  = state == PCL_LOAD && !shift_empty;
   wire read_step   = state == PCL_READ && !shift_full && read_pace == `PCL_PACE_LAST;

   always_comb begin
      next_state = state;
      unique case (state)
         PCL_IDLE: begin
            if (csr_wr && !cfg_req.wdata[`PCL_BIT_RDBACK_N])
               next_state = PCL_READ;
            else if (csr_wr && wr_config && !config_bit)
               next_state = PCL_CLEAR;
         end
         PCL_CLEAR: begin
            if (clear_last)
               next_state = PCL_LOAD;
         end
         PCL_LOAD: begin
            if (csr_wr && !wr_config)
               next_state = PCL_IDLE;
         end
         PCL_READ: begin
            if (!rdback_bit_n)
               next_state = PCL_READ;
            else
               next_state = PCL_IDLE;
         end
      endcase
      if (kill)
         next_state = PCL_IDLE;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= PCL_IDLE;
         ctrl  <= `PCL_CTRL_RESET;
      end else begin
         state <= next_state;
         if (csr_wr)
            ctrl <= {cfg_req.wdata[`PCL_BIT_RDBACK_N], wr_config, cfg_req.wdata[`PCL_BIT_PROGRAM_N]};
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         clear_count <= `PCL_CLEAR_ZERO;
         init_ok     <= 1'b0;
      end else begin
         if (state == PCL_CLEAR)
            clear_count <= clear_count + `PCL_CLEAR_ONE;
         else
            clear_count <= `PCL_CLEAR_ZERO;
         if (kill || next_state == PCL_CLEAR)
            init_ok <= 1'b0;
         else if (state == PCL_CLEAR && clear_last)
            init_ok <= 1'b1;
      end
   end

   // write sets valid, wins over the move
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         data_word   <= `PCL_WORD_ZERO;
         word_valid  <= 1'b0;
         shift_word  <= `PCL_WORD_ZERO;
         shift_count <= `PCL_SHIFT_ZERO;
         shift_empty <= 1'b1;
         shift_full  <= 1'b0;
      end else begin
         if (data_wr) begin
            data_word  <= cfg_req.wdata;
            word_valid <= 1'b1;
         end else if (take_word || kill) begin
            word_valid <= 1'b0;
         end
         if (take_word) begin
            shift_word  <= data_word;
            shift_count <= `PCL_SHIFT_ZERO;
            shift_empty <= 1'b0;
         end else if (shift_step) begin
            shift_word  <= {shift_word[30:0], 1'b0};
            shift_count <= shift_count + `PCL_SHIFT_ONE;
            if (shift_last)
               shift_empty <= 1'b1;
         end else if (read_step) begin
            shift_word  <= {shift_word[30:0], rdbit_sync};
            shift_count <= shift_count + `PCL_SHIFT_ONE;
         end else if (kill || state == PCL_IDLE) begin
            shift_count <= `PCL_SHIFT_ZERO;
            shift_empty <= 1'b1;
         end
         if (read_step && shift_last) begin
            data_word  <= {shift_word[30:0], rdbit_sync};
            shift_full <= 1'b1;
         end else if (data_rd || state != PCL_READ) begin
            shift_full <= 1'b0;
         end
      end
   end

   // pace readback bits
   // Far side moves on the registered shift pulse; the new bit then needs two edges to clear the synchroniser
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         read_pace <= `PCL_PACE_ZERO;
      else if (state == PCL_READ && !shift_full)
         read_pace <= read_pace + `PCL_PACE_ONE;
      else
         read_pace <= `PCL_PACE_ZERO;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         done_flag        <= 1'b0;
         cfg_serial_data  <= 1'b0;
         cfg_serial_valid <= 1'b0;
         cfg_abort_strap  <= 1'b0;
         rdback_shift     <= 1'b0;
      end else begin
         if (next_state == PCL_CLEAR || kill)
            done_flag <= 1'b0;
         else if (done_sync[0] || done_sync[1])
            done_flag <= 1'b1;
         cfg_serial_data  <= shift_word[31];
         cfg_serial_valid <= shift_step;
         cfg_abort_strap  <= next_state != PCL_IDLE && src_sync.strap_busy;
         rdback_shift     <= read_step;
      end
   end

   wire [15:0] csr_image = {5'h00, ctrl, 2'h0, shift_full, shift_empty,
                            word_valid, init_ok, done_flag, !scan_hold};
   // data reads clear the full flag; other reads have no side effect
   wire [31:0] next_rdata = csr_hit  ? {16'h0000, csr_image} :
                            data_hit ? data_word : `PCL_WORD_ZERO;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         cfg_rdata <= `PCL_WORD_ZERO;
      else
         cfg_rdata <= next_rdata;
   end

endmodule

// [bench/pcl_loader_props.sv]
`timescale 1ns/1ps
module pcl_loader_props
   import pcl_pkg::*;
(
   // Clock and reset
   input wire logic            mclk,
   input wire logic            rst,
   // Observed ports
   input wire pcl_cfg_req_type cfg_req,
   input wire logic [31:0]     cfg_rdata,
   input wire pcl_sources_type sources,
   input wire logic            cfg_serial_valid,
   input wire logic            cfg_abort_strap,
   input wire logic            rdback_shift
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   property p_unmapped; cfg_req.addr != 8'h40 && cfg_req.addr != 8'h44 |=> cfg_rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_width; cfg_req.addr == 8'h40 |=> cfg_rdata[31:11] == 21'h0 && cfg_rdata[7:6] == 2'h0; endproperty
   a_width: assert property (p_width) else $error("status upper bits set");
   property p_scan_low; sources.scan_busy [*5] ##0 cfg_req.addr == 8'h40 |=> !cfg_rdata[0]; endproperty
   a_scan_low: assert property (p_scan_low) else $error("scan idle high while busy");
   property p_valid; cfg_req.wr && cfg_req.addr == 8'h44 ##1 cfg_req.addr == 8'h40 |=> cfg_rdata[3]; endproperty
   a_valid: assert property (p_valid) else $error("valid not set by data write");
   property p_strap; !sources.strap_busy [*5] |=> !cfg_abort_strap; endproperty
   a_strap: assert property (p_strap) else $error("abort without strap load");
   property p_pin; !sources.program_pin_n [*5] |=> !cfg_serial_valid && !cfg_abort_strap; endproperty
   a_pin: assert property (p_pin) else $error("session alive with pin low");
   property p_scan_wins; sources.scan_busy [*5] |=> !cfg_serial_valid; endproperty
   a_scan_wins: assert property (p_scan_wins) else $error("shifting during scan access");
   property p_one_mode; rdback_shift |-> !cfg_serial_valid; endproperty
   a_one_mode: assert property (p_one_mode) else $error("load and readback together");
endmodule
bind pcl_loader pcl_loader_props props (.mclk, .rst, .cfg_req, .cfg_rdata, .sources, .cfg_serial_valid,
   .cfg_abort_strap, .rdback_shift);

// [bench/pcl_cfg_model.sv]
`timescale 1ns/1ps
module pcl_cfg_model #(
   parameter int          LOAD_BITS = 96,
   parameter logic [31:0] PATTERN   = 32'hC3A5_0F96
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // Serial side of the loader
   input  wire logic        cfg_serial_data,
   input  wire logic        cfg_serial_valid,
   input  wire logic        rdback_shift,
   output logic             cfg_load_done,
   output logic             rdback_bit,
   output logic [31:0]      last_word
);
   int         bit_count;
   logic [4:0] rd_index;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bit_count <= 0;
         rd_index <= 5'h00;
         last_word <= 32'h0;
      end else begin
         if (cfg_serial_valid) begin
            bit_count <= bit_count + 1;
            last_word <= {last_word[30:0], cfg_serial_data};
         end
         if (rdback_shift) begin
            rd_index <= rd_index + 5'h01;
         end
      end
   end
   assign cfg_load_done = bit_count >= LOAD_BITS;
   assign rdback_bit = PATTERN[5'h1F - rd_index];
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
   import pcl_pkg::*;
   logic            mclk = 1'b0;
   logic            rst = 1'b1;
   pcl_cfg_req_type cfg_req = '0;
   pcl_sources_type sources = 3'h1;
   logic [31:0]     cfg_rdata, last_word, rv;
   logic            ser_d, ser_v, abort_s, load_done, rb_bit, rb_shift;
   logic            preconfig = 1'b0;
   int              bad_count = 0;
   int              checks = 0;
   always #25 mclk = ~mclk;
   pcl_loader dut (.mclk(mclk), .rst(rst), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .sources(sources),
      .preconfig_done(preconfig), .cfg_serial_data(ser_d), .cfg_serial_valid(ser_v), .cfg_abort_strap(abort_s),
      .cfg_load_done(load_done), .rdback_bit(rb_bit), .rdback_shift(rb_shift));
   pcl_cfg_model model (.mclk(mclk), .rst(rst), .cfg_serial_data(ser_d), .cfg_serial_valid(ser_v),
      .rdback_shift(rb_shift), .cfg_load_done(load_done), .rdback_bit(rb_bit), .last_word(last_word));
   task automatic summarize();
      if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // Address falls back to the status register so flag updates show at once
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge mclk);
      cfg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge mclk);
      cfg_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h40, wdata: d};
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(negedge mclk);
      cfg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(negedge mclk);
      cfg_req.rd = 1'b0;
      d = cfg_rdata;
   endtask
   task automatic poll(input int b, input logic v);
      logic [31:0] d;
      for (int i = 0; i < 200; i++) begin
         rd(8'h40, d);
         if (d[b] === v) return;
      end
      chk("status poll", d[b], v);
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      repeat (3) @(negedge mclk);
      rd(8'h40, rv);
      chk("status reset", rv, 32'h0000_0511);
      rd(8'h40, rv);
      chk("status reread", rv, 32'h0000_0511);
      rd(8'h48, rv);
      chk("unmapped", rv, 32'h0);
      preconfig = 1'b1;
      repeat (4) @(negedge mclk);
      rd(8'h40, rv);
      chk("done preconfig", rv[1], 1'b1);
      preconfig = 1'b0;
      sources.strap_busy = 1'b1;
      wr(8'h40, 32'h0500);
      wr(8'h40, 32'h0400);
      wr(8'h40, 32'h0500);
      wr(8'h40, 32'h0700);
      poll(2, 1'b1);
      chk("strap abort", abort_s, 1'b1);
      sources.strap_busy = 1'b0;
      wr(8'h44, 32'hFFFF_FFFF);
      poll(4, 1'b1);
      wr(8'h44, 32'h1234_ABCD);
      wr(8'h44, 32'h8001_7FFE);
      rd(8'h40, rv);
      chk("valid held", rv[3], 1'b1);
      poll(3, 1'b0);
      poll(4, 1'b1);
      rd(8'h40, rv);
      chk("valid moved", rv[3], 1'b0);
      chk("serial word", last_word, 32'h8001_7FFE);
      repeat (4) @(negedge mclk);
      rd(8'h40, rv);
      chk("done", rv[1], 1'b1);
      wr(8'h40, 32'h0500);
      wr(8'h40, 32'h0100);
      for (int i = 0; i < 2; i++) begin
         poll(5, 1'b1);
         rd(8'h44, rv);
         chk("readback word", rv, 32'hC3A5_0F96);
      end
      wr(8'h40, 32'h0500);
      wr(8'h40, 32'h0700);
      wr(8'h44, 32'hFFFF_FFFF);
      poll(3, 1'b0);
      poll(4, 1'b1);
      wr(8'h40, 32'h0500);
      wr(8'h40, 32'h0700);
      poll(2, 1'b1);
      sources.program_pin_n = 1'b0;
      repeat (6) @(negedge mclk);
      sources.program_pin_n = 1'b1;
      rd(8'h40, rv);
      chk("pin abort", rv[2], 1'b0);
      sources.scan_busy = 1'b1;
      wr(8'h40, 32'h0500);
      wr(8'h40, 32'h0700);
      repeat (25) @(negedge mclk);
      rd(8'h40, rv);
      chk("scan wins", {rv[2], rv[0]}, 2'h0);
      sources.scan_busy = 1'b0;
      poll(0, 1'b1);
      summarize();
   end
endmodule
